// file: hdl/cdus_pkg.sv
// Constants, register map and mode codes for the current DAC update scheduler.
// Assumes a 32-bit APB slave with word registers at four times the index.
package cdus_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] CDUS_IDX_CTRL = 8'hb9;
	localparam logic [7:0] CDUS_IDX_HIGH = 8'h97;
	localparam logic [7:0] CDUS_IDX_LOW = 8'h96;
	localparam logic [7:0] CDUS_IDX_BIAS = 8'hd1;
	localparam logic [7:0] CDUS_IDX_STAT = 8'h98;

	localparam int CDUS_AW = 12;
	localparam logic [11:0] CDUS_ADDR_CTRL = {2'b00, CDUS_IDX_CTRL, 2'b00};
	localparam logic [11:0] CDUS_ADDR_HIGH = {2'b00, CDUS_IDX_HIGH, 2'b00};
	localparam logic [11:0] CDUS_ADDR_LOW = {2'b00, CDUS_IDX_LOW, 2'b00};
	localparam logic [11:0] CDUS_ADDR_BIAS = {2'b00, CDUS_IDX_BIAS, 2'b00};
	localparam logic [11:0] CDUS_ADDR_STAT = {2'b00, CDUS_IDX_STAT, 2'b00};

	// Control, bias and status register field positions
	localparam int CDUS_CTRL_EN_BIT = 7;
	localparam int CDUS_CTRL_MODE_HI = 6;
	localparam int CDUS_CTRL_MODE_LO = 4;
	localparam int CDUS_CTRL_FSR_HI = 1;
	localparam int CDUS_CTRL_FSR_LO = 0;
	localparam int CDUS_BIAS_MAN_BIT = 1;
	localparam int CDUS_STAT_PEND_BIT = 16;
	localparam int CDUS_STAT_BIAS_BIT = 17;

	// Reset values and range codes
	localparam logic [7:0] CDUS_CTRL_RST = 8'h72;
	localparam logic [7:0] CDUS_HIGH_RST = 8'h00;
	localparam logic [1:0] CDUS_LOW_RST = 2'h0;
	localparam logic [9:0] CDUS_WORD_RST = 10'h000;
	localparam logic [1:0] CDUS_FSR_2MA = 2'h2;
	localparam logic [1:0] CDUS_FSR_1MA = 2'h1;
	localparam logic [1:0] CDUS_FSR_HALF_MA = 2'h0;

	localparam int CDUS_NUM_TIMERS = 4;

	typedef enum logic [2:0]
	{
		CDUS_MODE_TMR0 = 3'b000,
		CDUS_MODE_TMR1 = 3'b001,
		CDUS_MODE_TMR2 = 3'b010,
		CDUS_MODE_TMR3 = 3'b011,
		CDUS_MODE_RISE = 3'b100,
		CDUS_MODE_FALL = 3'b101,
		CDUS_MODE_BOTH = 3'b110,
		CDUS_MODE_WRITE = 3'b111
	} cdus_mode_e;

endpackage

// file: hdl/cdus_edge_if.sv
// Carrier for synchronised strobe-pin edges between scheduler modules.
// Assumes all signals are on the system clock.
`timescale 1ns/1ps
interface cdus_edge_if;
	logic rise;
	logic fall;
	logic level;
	modport src (output rise, output fall, output level);
	modport snk (input rise, input fall, input level);
endinterface // cdus_edge_if

// file: hdl/cdus_edge_sync.sv
// Synchroniser and edge detector for the external conversion-start pin.
// Assumes the pin is asynchronous to i_mclk.
`timescale 1ns/1ps
module cdus_edge_sync
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_pin,
	cdus_edge_if.src edge_bus
);
	logic [2:0] sync_q;
	logic level_q;
	logic rise_q;
	logic fall_q;

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			sync_q <= 3'h0;
		else
			sync_q <= {sync_q[1:0], i_pin};
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			level_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end
		else
		begin
			rise_q <= (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;
			fall_q <= (sync_q[1] == sync_q[2]) && !sync_q[2] && level_q;
			if (sync_q[1] == sync_q[2])
				level_q <= sync_q[2];
		end
	end

	assign edge_bus.rise = rise_q;
	assign edge_bus.fall = fall_q;
	assign edge_bus.level = level_q;
endmodule // cdus_edge_sync

// file: hdl/cdus_pin_mux.sv
// Shared pin control: ordinary port pin or current output.
// Assumes GPIO requests come from port logic on the same clock.
`timescale 1ns/1ps
module cdus_pin_mux
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_enable,
	input wire logic i_gpio_out,
	input wire logic i_gpio_oe,
	input wire logic i_gpio_pullup,
	output logic o_pin_out,
	output logic o_pin_oe,
	output logic o_pin_pullup,
	output logic o_pin_analog
);
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
		begin
			o_pin_out <= 1'b0;
			o_pin_oe <= 1'b0;
			o_pin_pullup <= 1'b0;
			o_pin_analog <= 1'b0;
		end
		else
		begin
			o_pin_out <= i_gpio_out && !i_enable;
			o_pin_oe <= i_gpio_oe && !i_enable;
			o_pin_pullup <= i_gpio_pullup && !i_enable;
			o_pin_analog <= i_enable;
		end
	end
endmodule // cdus_pin_mux

// file: hdl/cdus_top.sv
// Update scheduler for a 10-bit current-output converter, APB register slave.
// Assumes timer overflow pulses on i_mclk; strobe pin is asynchronous.
`timescale 1ns/1ps
module cdus_top
#(
	parameter int NUM_TIMERS = 4
)
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [cdus_pkg::CDUS_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [NUM_TIMERS-1:0] i_timer_ovf,
	input wire logic i_conv_start_pin,
	input wire logic i_bias_other_req,
	input wire logic i_gpio_out,
	input wire logic i_gpio_oe,
	input wire logic i_gpio_pullup,
	output logic o_pin_out,
	output logic o_pin_oe,
	output logic o_pin_pullup,
	output logic o_pin_analog,
	output logic [9:0] o_dac_word,
	output logic [1:0] o_full_scale_sel,
	output logic o_dac_enable,
	output logic o_bias_enable
);
	import cdus_pkg::*;

	cdus_edge_if edge_bus ();

	logic [7:0] ctrl_q;
	logic [7:0] high_q;
	logic [1:0] low_q;
	logic manual_bias_q;
	logic pending_q;
	logic [9:0] word_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic bias_q;
	logic [1:0] fsr_q;
	logic enable_q;

	logic access;
	logic wr_fire;
	logic rd_fire;
	logic addr_ok;
	logic wr_ctrl;
	logic wr_high;
	logic wr_low;
	logic wr_bias;
	logic [31:0] rd_data;
	logic trig;
	logic [NUM_TIMERS-1:0] tmr_sel;
	cdus_mode_e mode;
	logic [9:0] new_word;
	logic sel_ctrl;
	logic sel_high;
	logic sel_low;
	logic sel_bias;
	logic wr_lane0;
	logic data_wr;
	logic mode_write;
	logic tmr_hit;
	logic edge_hit;
	logic [9:0] held_word;

	assign mode = cdus_mode_e'(ctrl_q[CDUS_CTRL_MODE_HI:CDUS_CTRL_MODE_LO]);
	// Write mode bypasses the pending flag
	assign mode_write = (mode == CDUS_MODE_WRITE);

	cdus_edge_sync u_edge_sync
	(
		.i_mclk (i_mclk),
		.i_resetn (i_resetn),
		.i_pin (i_conv_start_pin),
		.edge_bus (edge_bus.src)
	);

	cdus_pin_mux u_pin_mux
	(
		.i_mclk (i_mclk),
		.i_resetn (i_resetn),
		.i_enable (ctrl_q[CDUS_CTRL_EN_BIT]),
		.i_gpio_out (i_gpio_out),
		.i_gpio_oe (i_gpio_oe),
		.i_gpio_pullup (i_gpio_pullup),
		.o_pin_out (o_pin_out),
		.o_pin_oe (o_pin_oe),
		.o_pin_pullup (o_pin_pullup),
		.o_pin_analog (o_pin_analog)
	);

	// APB: one wait state, so every answer comes from a flop
	assign access = i_psel && i_penable;
	assign wr_fire = access && pready_q && i_pwrite;
	assign rd_fire = access && !pready_q && !i_pwrite;

	always_comb
	begin
		addr_ok = 1'b1;
		case (i_paddr)
			CDUS_ADDR_CTRL: addr_ok = 1'b1;
			CDUS_ADDR_HIGH: addr_ok = 1'b1;
			CDUS_ADDR_LOW: addr_ok = 1'b1;
			CDUS_ADDR_BIAS: addr_ok = 1'b1;
			CDUS_ADDR_STAT: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	assign sel_ctrl = (i_paddr == CDUS_ADDR_CTRL);
	assign sel_high = (i_paddr == CDUS_ADDR_HIGH);
	assign sel_low = (i_paddr == CDUS_ADDR_LOW);
	assign sel_bias = (i_paddr == CDUS_ADDR_BIAS);

	// Only byte lane 0 holds writable register bits
	assign wr_lane0 = wr_fire && i_pstrb[0];
	assign wr_ctrl = wr_lane0 && sel_ctrl;
	assign wr_high = wr_lane0 && sel_high;
	assign wr_low = wr_lane0 && sel_low;
	assign wr_bias = wr_lane0 && sel_bias;
	assign data_wr = wr_high || wr_low;

	always_comb
	begin
		rd_data = 32'h0000_0000;
		case (i_paddr)
			CDUS_ADDR_CTRL: rd_data = {24'h00_0000, ctrl_q};
			CDUS_ADDR_HIGH: rd_data = {24'h00_0000, high_q};
			CDUS_ADDR_LOW: rd_data = {24'h00_0000, low_q, 6'h00};
			CDUS_ADDR_BIAS:
			begin
				rd_data[CDUS_BIAS_MAN_BIT] = manual_bias_q;
			end
			CDUS_ADDR_STAT:
			begin
				rd_data[9:0] = word_q;
				rd_data[CDUS_STAT_PEND_BIT] = pending_q;
				rd_data[CDUS_STAT_BIAS_BIT] = bias_q;
			end
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// Answer one cycle after the access phase opens
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			pready_q <= 1'b0;
		else
			pready_q <= access && !pready_q;
	end

	// Error flag rides with the ready pulse
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			pslverr_q <= 1'b0;
		else
			pslverr_q <= access && !pready_q && !addr_ok;
	end

	// Read data stands only with pready, zero otherwise
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			prdata_q <= 32'h0000_0000;
		else if (rd_fire)
			prdata_q <= rd_data;
		else
			prdata_q <= 32'h0000_0000;
	end

	// range field resets to 2 mA
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			ctrl_q <= CDUS_CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= {i_pwdata[7:4], 2'b00, i_pwdata[1:0]};
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			high_q <= CDUS_HIGH_RST;
		else if (wr_high)
			high_q <= i_pwdata[7:0];
	end

	// only bits 7 and 6 stored
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			low_q <= CDUS_LOW_RST;
		else if (wr_low)
			low_q <= i_pwdata[7:6];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			manual_bias_q <= 1'b0;
		else if (wr_bias)
			manual_bias_q <= i_pwdata[CDUS_BIAS_MAN_BIT];
	end

	genvar g;
	generate
		for (g = 0; g < NUM_TIMERS; g++)
		begin : g_tmr
			assign tmr_sel[g] = i_timer_ovf[g] && (32'(mode) == g);
		end
	endgenerate
	assign tmr_hit = |tmr_sel;

	always_comb
	begin
		edge_hit = 1'b0;
		case (mode)
			CDUS_MODE_RISE: edge_hit = edge_bus.rise;
			CDUS_MODE_FALL: edge_hit = edge_bus.fall;
			CDUS_MODE_BOTH: edge_hit = edge_bus.rise || edge_bus.fall;
			default: edge_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		trig = 1'b0;
		case (mode)
			CDUS_MODE_TMR0, CDUS_MODE_TMR1, CDUS_MODE_TMR2, CDUS_MODE_TMR3:
				trig = tmr_hit;
			CDUS_MODE_RISE, CDUS_MODE_FALL, CDUS_MODE_BOTH:
				trig = edge_hit;
			CDUS_MODE_WRITE: trig = 1'b0;
			default: trig = 1'b0;
		endcase
	end

	// held low bits join new high
	assign new_word = {i_pwdata[7:0], low_q};
	assign held_word = {high_q, low_q};

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			pending_q <= 1'b0;
		// Write in a trigger cycle keeps new data pending
		else if (data_wr)
			pending_q <= !mode_write;
		else if (trig)
			pending_q <= 1'b0;
	end

	// Output latch: write mode vs held-until-trigger modes
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			word_q <= CDUS_WORD_RST;
		else if (mode_write)
		begin
			if (wr_high)
				word_q <= new_word;
		end
		else if (trig && pending_q)
			word_q <= held_word;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			fsr_q <= CDUS_FSR_2MA;
		else if (ctrl_q[CDUS_CTRL_FSR_HI])
			fsr_q <= CDUS_FSR_2MA;
		else if (ctrl_q[CDUS_CTRL_FSR_LO])
			fsr_q <= CDUS_FSR_1MA;
		else
			fsr_q <= CDUS_FSR_HALF_MA;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			enable_q <= 1'b0;
		else
			enable_q <= ctrl_q[CDUS_CTRL_EN_BIT];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			bias_q <= 1'b0;
		else
			bias_q <= ctrl_q[CDUS_CTRL_EN_BIT] || manual_bias_q || i_bias_other_req;
	end

	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_dac_word = word_q;
	assign o_full_scale_sel = fsr_q;
	assign o_dac_enable = enable_q;
	assign o_bias_enable = bias_q;
endmodule // cdus_top

// file: dv/cdus_far_side.sv
// Far-side model: timer overflow pulses and the conversion-start pin.
// Assumes callers run just after a rising edge of i_mclk.
`timescale 1ns/1ps
module cdus_far_side
(
	input wire logic i_mclk,
	output logic [3:0] o_ovf,
	output logic o_pin
);
	initial
	begin
		o_ovf = 4'h0;
		o_pin = 1'b0;
	end
	// One-cycle pulse, as real timers give
	task automatic ovf(input int n);
		@(posedge i_mclk);
		o_ovf <= 4'h1 << n;
		@(posedge i_mclk);
		o_ovf <= 4'h0;
	endtask
	// Pin is asynchronous; level only
	task automatic pin(input logic v);
		@(posedge i_mclk);
		o_pin <= v;
	endtask
endmodule // cdus_far_side

// file: dv/cdus_monitor.sv
// Port checker for the converter update scheduler.
// Assumes it is bound to cdus_top and sees only its ports.
`timescale 1ns/1ps
module cdus_monitor
#(
	parameter int NUM_TIMERS = 4
)
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [cdus_pkg::CDUS_AW-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [NUM_TIMERS-1:0] i_timer_ovf,
	input wire logic i_conv_start_pin,
	input wire logic o_pin_out,
	input wire logic o_pin_oe,
	input wire logic o_pin_pullup,
	input wire logic o_pin_analog,
	input wire logic [9:0] o_dac_word,
	input wire logic [1:0] o_full_scale_sel,
	input wire logic o_dac_enable,
	input wire logic o_bias_enable
);
	import cdus_pkg::*;
	logic [2:0] mode_q;
	logic pin_q;
	logic [3:0] quiet_q;
	logic wr_c;
	assign wr_c = o_pready && i_psel && i_penable && i_pwrite && i_pstrb[0];
	always_ff @(posedge i_mclk)
	begin
		if (!i_resetn)
			mode_q <= 3'h7;
		else if (wr_c && i_paddr == CDUS_ADDR_CTRL)
			mode_q <= i_pwdata[6:4];
	end
	// Pin edges reach the word only after the synchroniser
	always_ff @(posedge i_mclk)
	begin
		pin_q <= i_conv_start_pin;
		if (!i_resetn || pin_q != i_conv_start_pin)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	property p_pin_off;
		o_pin_analog |-> !o_pin_oe && !o_pin_pullup && !o_pin_out;
	endproperty
	property p_bias;
		o_dac_enable |-> o_bias_enable;
	endproperty
	property p_rdy_one;
		o_pready |=> !o_pready;
	endproperty
	property p_rdy_acc;
		o_pready |-> i_psel && i_penable;
	endproperty
	property p_err;
		o_pslverr |-> o_pready;
	endproperty
	property p_rd0;
		!o_pready |-> o_prdata == 32'h0;
	endproperty
	property p_high;
		mode_q == 3'h7 && wr_c && i_paddr == CDUS_ADDR_HIGH
			|=> o_dac_word[9:2] == $past(i_pwdata[7:0]);
	endproperty
	property p_low;
		mode_q == 3'h7 && wr_c && i_paddr == CDUS_ADDR_LOW |=> $stable(o_dac_word);
	endproperty
	property p_cause;
		$changed(o_dac_word) |-> $past(wr_c) || $past(|i_timer_ovf) || quiet_q < 4'ha;
	endproperty
	property p_fsr;
		$rose(i_resetn) |-> o_full_scale_sel == CDUS_FSR_2MA;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin driven while enabled");
	a_bias: assert property (p_bias) else $error("bias off while enabled");
	a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
	a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_rd0: assert property (p_rd0) else $error("prdata not zero when idle");
	a_high: assert property (p_high) else $error("high write did not update");
	a_low: assert property (p_low) else $error("low write changed word");
	a_cause: assert property (p_cause) else $error("word changed untriggered");
	a_fsr: assert property (p_fsr) else $error("range not 2 mA after reset");
	c_high: cover property (mode_q == 3'h7 && wr_c && i_paddr == CDUS_ADDR_HIGH);
	c_tmr: cover property (|i_timer_ovf ##1 $changed(o_dac_word));
	c_err: cover property (o_pslverr);
	c_edge: cover property ($rose(i_conv_start_pin) ##5 $changed(o_dac_word));
endmodule // cdus_monitor

bind cdus_top cdus_monitor #(.NUM_TIMERS(NUM_TIMERS)) u_cdus_monitor (.*);

// file: dv/tb_current_dac_update_scheduler.sv
// Self-checking bench for the converter update scheduler.
// Assumes an APB slave that answers with pready and a far-side model.
`timescale 1ns/1ps
module tb_current_dac_update_scheduler;
	import cdus_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic gout = 1'b0;
	logic goe = 1'b0;
	logic gpu = 1'b0;
	logic [3:0] pstrb = 4'hf;
	logic boreq = 1'b0;
	logic [31:0] prdata;
	logic prdy, perr, pin, pout, poe, ppu, pan, den, ben;
	logic [3:0] ovf;
	logic [9:0] word;
	logic [1:0] fsr;
	logic [9:0] exp = 10'h0;
	int bad_count = 0;
	int comparisons = 0;
	always #5 mclk = ~mclk;
	cdus_top u_cdus_top (.i_mclk(mclk), .i_resetn(resetn), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(pstrb), .o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr),
		.i_timer_ovf(ovf), .i_conv_start_pin(pin), .i_bias_other_req(boreq),
		.i_gpio_out(gout), .i_gpio_oe(goe), .i_gpio_pullup(gpu), .o_pin_out(pout),
		.o_pin_oe(poe), .o_pin_pullup(ppu), .o_pin_analog(pan), .o_dac_word(word),
		.o_full_scale_sel(fsr), .o_dac_enable(den), .o_bias_enable(ben));
	cdus_far_side u_cdus_far_side (.i_mclk(mclk), .o_ovf(ovf), .o_pin(pin));
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic nap(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (prdy !== 1'b1 && n < 20);
		r = prdata;
		e = perr;
		if (n >= 20)
			chk(32'h0, 32'h1);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
	endtask
	task automatic t_reset;
		rd(CDUS_ADDR_CTRL, 32'h72);
		rd(CDUS_ADDR_HIGH, 32'h0);
		rd(CDUS_ADDR_LOW, 32'h0);
		chk(fsr, CDUS_FSR_2MA);
	endtask
	task automatic t_bad_addr;
		logic [31:0] r;
		logic e;
		wr(12'h000, 8'h5a);
		apb(1'b0, 12'h000, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		rd(CDUS_ADDR_CTRL, 32'h72);
		pstrb <= 4'h0;
		wr(CDUS_ADDR_HIGH, 8'h55);
		pstrb <= 4'hf;
		rd(CDUS_ADDR_HIGH, 32'h0);
		chk(word, 10'h0);
	endtask
	task automatic t_write;
		wr(CDUS_ADDR_LOW, 8'hff);
		rd(CDUS_ADDR_LOW, 32'hc0);
		nap(3);
		chk(word, 10'h0);
		wr(CDUS_ADDR_HIGH, 8'ha5);
		nap(3);
		chk(word, 10'h297);
		wr(CDUS_ADDR_HIGH, 8'h3c);
		nap(3);
		exp = 10'h0f3;
		chk(word, exp);
	endtask
	task automatic t_timer;
		for (int m = 0; m < 4; m++)
		begin
			wr(CDUS_ADDR_CTRL, 8'h02 | 8'(m << 4));
			wr(CDUS_ADDR_LOW, 8'h40);
			wr(CDUS_ADDR_HIGH, 8'(8'h10 + m));
			u_cdus_far_side.ovf((m + 1) % 4);
			nap(3);
			chk(word, exp);
			rd(CDUS_ADDR_STAT, {15'h0, 1'b1, 6'h0, exp});
			u_cdus_far_side.ovf(m);
			nap(3);
			exp = {8'(8'h10 + m), 2'b01};
			chk(word, exp);
		end
	endtask
	task automatic t_edge;
		for (int m = 4; m < 7; m++)
		begin
			wr(CDUS_ADDR_CTRL, 8'h02 | 8'(m << 4));
			wr(CDUS_ADDR_HIGH, 8'(8'h80 + m));
			u_cdus_far_side.pin(1'b1);
			nap(8);
			if (m != 5)
				exp = {8'(8'h80 + m), 2'b01};
			chk(word, exp);
			wr(CDUS_ADDR_HIGH, 8'(8'hc0 + m));
			u_cdus_far_side.pin(1'b0);
			nap(8);
			if (m != 4)
				exp = {8'(8'hc0 + m), 2'b01};
			chk(word, exp);
		end
		rd(CDUS_ADDR_STAT, 32'(exp));
	endtask
	task automatic t_enable;
		gout <= 1'b1;
		goe <= 1'b1;
		gpu <= 1'b1;
		nap(3);
		chk({pout, poe, ppu, pan}, 4'he);
		wr(CDUS_ADDR_BIAS, 8'h02);
		nap(3);
		chk(ben, 1'b1);
		rd(CDUS_ADDR_BIAS, 32'h2);
		wr(CDUS_ADDR_BIAS, 8'h00);
		boreq <= 1'b1;
		nap(3);
		chk(ben, 1'b1);
		boreq <= 1'b0;
		// pin skip is set in the crossbar, outside
		wr(CDUS_ADDR_CTRL, 8'h81);
		nap(3);
		chk({pout, poe, ppu, pan, den, ben, fsr}, 8'h1d);
		wr(CDUS_ADDR_CTRL, 8'h80);
		nap(3);
		chk(fsr, CDUS_FSR_HALF_MA);
		wr(CDUS_ADDR_CTRL, 8'h03);
		nap(3);
		chk({pout, poe, ppu, pan, fsr}, 6'h3a);
	endtask
	initial
	begin
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		t_reset;
		t_bad_addr;
		t_write;
		t_timer;
		t_edge;
		t_enable;
		wrap_up;
	end
	// Whole run is well under a few thousand cycles
	initial
	begin
		#200000;
		bad_count++;
		wrap_up;
	end
endmodule // tb_current_dac_update_scheduler
